// [bench/cli_core_tb.sv]
// Self-checking bench for the LCD instruction core.
`include "cli_defs.svh"
`default_nettype none
module cli_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned POR = 200;
  logic pclk = 1'b0;
  logic presetn;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [7:0] paddr;
  wire logic [31:0] pwdata, prdata;
  logic three_line_strap;
  logic bias_option_strap_a;
  logic bias_option_strap_b;
  logic ext_reset_n;
  wire cli_pkg::cli_cfg_t cfg;
  wire logic busy_flag, double_top, double_bottom;
  wire logic [6:0] address_counter;
  logic [7:0] s;
  int err_total = 0;
  int total_checks = 0;
  int ticks = 0;

  always #12.5 pclk = ~pclk;

  cli_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  cli_core #(.POR_CYCLES(POR)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .three_line_strap(three_line_strap),
    .bias_option_strap_a(bias_option_strap_a),
    .bias_option_strap_b(bias_option_strap_b),
    .ext_reset_n(ext_reset_n), .cfg(cfg), .busy_flag(busy_flag),
    .address_counter(address_counter), .double_top(double_top),
    .double_bottom(double_bottom));

  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Roughly fifty executions of 1052 cycles fit well inside this.
  always @(posedge pclk) begin
    ticks <= ticks + 1;
    if (ticks == 95000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ac_is(input logic [6:0] a);
    host.stat(s);
    check(32'(s[6:0]), 32'(a));
    check(32'(address_counter), 32'(a));
  endtask

  task automatic rd_is(input logic [7:0] b);
    host.rdd(s);
    check(32'(s), 32'(b));
  endtask

  initial begin
    presetn <= 1'b0;
    three_line_strap <= 1'b0;
    bias_option_strap_a <= 1'b0;
    bias_option_strap_b <= 1'b0;
    ext_reset_n <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(busy_flag), 32'h1);
    check(32'(cfg), 32'(`CLI_CFG_RST));
    host.ins(8'h80);
    rd_is(`CLI_SPACE);
    host.ins(8'h85);
    host.xfer(1'b1, `CLI_OFS_INSTR, 32'h8a);
    check(32'(busy_flag), 32'h1);
    ac_is(7'h05);
    host.wrd(8'h41);
    ac_is(7'h06);
    host.wrd(8'h42);
    host.ins(8'h42);
    host.wrd(8'h55);
    ac_is(7'h03);
    host.ins(8'h85);
    rd_is(8'h41);
    rd_is(8'h42);
    host.ins(8'h42);
    rd_is(8'h55);
    host.ins(8'h04);
    host.ins(8'h42);
    rd_is(8'h55);
    ac_is(7'h01);
    host.ins(8'h85);
    host.wrd(8'h00);
    ac_is(7'h04);
    host.ins(8'h06);
    host.ins(8'h80 | 8'(`CLI_ONE_LAST));
    host.wrd(8'h31);
    ac_is(7'h00);
    host.ins(8'h38);
    host.ins(8'h80 | 8'(`CLI_TWO_L1_LAST));
    host.wrd(8'h32);
    ac_is(`CLI_TWO_L2_FIRST);
    host.ins(8'h80 | 8'(`CLI_TWO_L2_LAST));
    host.wrd(8'h33);
    ac_is(7'h00);
    // Table one, straps low: every power setting is taken.
    host.ins(8'h39);
    host.ins(8'h1c);
    host.ins(8'h5e);
    host.ins(8'h6d);
    host.ins(8'h7a);
    check(32'(cfg.table_select), 32'h1);
    check(32'(cfg.bias_select), 32'h1);
    check(32'({cfg.icon_on, cfg.boost_on}), 32'h3);
    check(32'({cfg.follow_on, cfg.gain_ratio_field}), 32'hd);
    check(32'(cfg.contrast_field), 32'h2a);
    host.ins(8'h43);
    ac_is(7'h03);
    host.wrd(8'h1f);
    host.ins(8'h43);
    rd_is(8'h1f);
    // Straps high: bias and power settings hold, icon enable still moves.
    bias_option_strap_a <= 1'b1;
    bias_option_strap_b <= 1'b1;
    host.ins(8'h14);
    host.ins(8'h78);
    host.ins(8'h52);
    host.ins(8'h62);
    check(32'(cfg.bias_select), 32'h1);
    check(32'({cfg.icon_on, cfg.boost_on}), 32'h1);
    check(32'({cfg.follow_on, cfg.gain_ratio_field}), 32'hd);
    check(32'(cfg.contrast_field), 32'h2a);
    bias_option_strap_a <= 1'b0;
    bias_option_strap_b <= 1'b0;
    host.ins(8'h28);
    host.nib = 1'b1;
    check(32'(cfg.bus_width_bit), 32'h0);
    host.ins(8'h92);
    ac_is(7'h12);
    host.wrd(8'h5a);
    ac_is(7'h13);
    host.ins(8'h38);
    host.nib = 1'b0;
    host.ins(8'h92);
    rd_is(8'h5a);
    host.ins(8'h0f);
    check(32'({cfg.disp_on, cfg.cursor_on, cfg.blink_on}), 32'h7);
    three_line_strap <= 1'b1;
    ext_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_reset_n <= 1'b1;
    @(posedge pclk);
    check(32'(cfg), 32'(`CLI_CFG_RST | 25'h2000));
    check(32'(busy_flag), 32'h1);
    host.ins(8'h3e);
    host.ins(8'h18);
    // The row flags are registered from the settings, one edge later.
    @(posedge pclk);
    check(32'({double_top, double_bottom}), 32'h2);
    host.ins(8'h10);
    @(posedge pclk);
    check(32'({double_top, double_bottom}), 32'h1);
    host.ins(8'h80 | 8'(`CLI_THREE_LAST));
    host.wrd(8'h34);
    ac_is(7'h00);
    host.xfer(1'b0, 8'h0c, 32'h0);
    check(32'(host.err), 32'h1);
    host.xfer(1'b0, `CLI_OFS_SET, 32'h0);
    check(32'(host.err), 32'h0);
    check(host.rd, 32'h01e1_2140);
    presetn <= 1'b0;
    @(posedge pclk);
    check(32'(cfg), 32'(`CLI_CFG_RST));
    check(32'(address_counter), 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(32'(busy_flag), 32'h1);
    check(32'(cfg), 32'(`CLI_CFG_RST | 25'h2000));
    complete_run();
  end
endmodule
`default_nettype wire

// [bench/cli_host.sv]
// Host processor model driving the core through its APB port.
`include "cli_defs.svh"
`default_nettype none
module cli_host (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nib = 1'b0;
  logic [31:0] rd;
  logic err;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; entered just after a rising edge, leaves one edge idle.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // The lower lines carry the inverse nibble so that using them shows.
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    if (nib) begin
      xfer(1'b1, a, {24'h0, b[7:4], ~b[7:4]});
      xfer(1'b1, a, {24'h0, b[3:0], ~b[3:0]});
    end else begin
      xfer(1'b1, a, {24'h0, b});
    end
  endtask

  task automatic stat(output logic [7:0] s);
    xfer(1'b0, `CLI_OFS_INSTR, 32'h0);
    s = rd[7:0];
    if (nib) begin
      xfer(1'b0, `CLI_OFS_INSTR, 32'h0);
      s = {s[7:4], rd[7:4]};
    end
  endtask

  // Polls busy, so nothing is sent during start-up or execution.
  task automatic idle();
    logic [7:0] s;
    do begin
      stat(s);
    end while (s[7] !== 1'b0);
  endtask

  task automatic ins(input logic [7:0] b);
    idle();
    put(`CLI_OFS_INSTR, b);
  endtask

  task automatic wrd(input logic [7:0] b);
    idle();
    put(`CLI_OFS_DATA, b);
  endtask

  // Callers load an address before reading, so no stale first read.
  task automatic rdd(output logic [7:0] b);
    idle();
    xfer(1'b0, `CLI_OFS_DATA, 32'h0);
    b = rd[7:0];
  endtask
endmodule
`default_nettype wire

// [src/cli_core.sv]
// Instruction interpreter of a character LCD controller behind APB.
`include "cli_defs.svh"
`default_nettype none
module cli_core #(
  parameter int unsigned POR_CYCLES = `CLI_POR_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps and external reset
  input wire logic three_line_strap,
  input wire logic bias_option_strap_a,
  input wire logic bias_option_strap_b,
  input wire logic ext_reset_n,
  // Settings and state
  output cli_pkg::cli_cfg_t cfg,
  output logic busy_flag,
  output logic [6:0] address_counter,
  output logic double_top,
  output logic double_bottom
);
  localparam int unsigned MAXC =
    (POR_CYCLES > `CLI_EXEC_CYC) ? POR_CYCLES : `CLI_EXEC_CYC;
  localparam int CW = $clog2(MAXC + 1);
  localparam logic [CW-1:0] EXEC_LOAD = CW'(`CLI_EXEC_CYC - 1);
  localparam logic [CW-1:0] POR_LOAD = CW'(POR_CYCLES - 1);

  // ************************************************************
  // Storage and decode
  // ************************************************************
  logic [7:0] dd_mem [0:127];
  logic [7:0] cg_mem [0:63];
  logic [7:0] icon_mem [0:15];
  cli_pkg::cli_mem_t mem_sel;
  logic [CW-1:0] cnt;
  logic init_pend, nib_phase, clr_busy, load;
  logic [3:0] nib_hold;
  logic [6:0] clr_addr, next_ac;
  logic [7:0] rd_latch, wbyte, rbyte;
  logic [31:0] rd_word;
  logic acc, take, hit_ins, hit_dat, hit_set, bus8, straps_low, straps_high;
  logic wr_any, wr_full, rd_any, rd_full, ins_go, dat_wr, dat_rd;
  logic init_go, three, tbl0, tbl1, tbl2;

  assign acc = psel & penable & ~pready;
  assign take = psel & penable & pready;
  assign hit_ins = paddr == `CLI_OFS_INSTR;
  assign hit_dat = paddr == `CLI_OFS_DATA;
  assign hit_set = paddr == `CLI_OFS_SET;
  assign bus8 = cfg.bus_width_bit;
  assign straps_low = ~bias_option_strap_a & ~bias_option_strap_b;
  assign straps_high = bias_option_strap_a & bias_option_strap_b;
  assign init_go = init_pend | ~ext_reset_n;
  assign three = three_line_strap & cfg.two_line;
  assign tbl0 = cfg.table_select == 2'b00;
  assign tbl1 = cfg.table_select == 2'b01;
  assign tbl2 = cfg.table_select == 2'b10;

  // Writes arriving while busy are dropped, nibble by nibble.
  assign wr_any = take & pwrite & (hit_ins | hit_dat) & ~busy_flag;
  assign wr_full = wr_any & (bus8 | nib_phase);
  assign wbyte = bus8 ? pwdata[7:0] : {nib_hold, pwdata[7:4]};
  assign rd_any = take & ~pwrite & (hit_ins | (hit_dat & ~busy_flag));
  assign rd_full = rd_any & (bus8 | nib_phase);
  assign ins_go = wr_full & hit_ins;
  assign dat_wr = wr_full & hit_dat;
  assign dat_rd = rd_full & hit_dat;

  function automatic logic [6:0] step_ac(input logic [6:0] a,
                                         input logic up,
                                         input cli_pkg::cli_mem_t s,
                                         input logic two,
                                         input logic thr);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    unique case (s)
      cli_pkg::MEM_CG: r[6] = 1'b0;
      cli_pkg::MEM_ICON: r[6:4] = 3'h0;
      cli_pkg::MEM_DD: begin
        if (thr) begin
          if (up && a == `CLI_THREE_LAST) r = 7'h00;
          else if (!up && a == 7'h00) r = `CLI_THREE_LAST;
        end else if (two) begin
          if (up && a == `CLI_TWO_L1_LAST) r = `CLI_TWO_L2_FIRST;
          else if (up && a == `CLI_TWO_L2_LAST) r = 7'h00;
          else if (!up && a == `CLI_TWO_L2_FIRST) r = `CLI_TWO_L1_LAST;
          else if (!up && a == 7'h00) r = `CLI_TWO_L2_LAST;
        end else begin
          if (up && a == `CLI_ONE_LAST) r = 7'h00;
          else if (!up && a == 7'h00) r = `CLI_ONE_LAST;
        end
      end
      default: r = a;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] mem_rd(input cli_pkg::cli_mem_t s,
                                        input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      cli_pkg::MEM_DD: v = dd_mem[a];
      cli_pkg::MEM_CG: v = cg_mem[a[5:0]];
      cli_pkg::MEM_ICON: v = icon_mem[a[3:0]];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ************************************************************
  // Address counter and memory select
  // ************************************************************
  cli_pkg::cli_mem_t next_sel;
  always_comb begin
    next_ac = address_counter;
    next_sel = mem_sel;
    load = 1'b0;
    if (init_go) begin
      next_ac = 7'h00;
      next_sel = cli_pkg::MEM_DD;
    end else if (ins_go) begin
      if (wbyte[7]) begin
        next_ac = wbyte[6:0];
        next_sel = cli_pkg::MEM_DD;
        load = 1'b1;
      end else if (wbyte[7:6] == 2'b01 && tbl0) begin
        next_ac = {1'b0, wbyte[5:0]};
        next_sel = cli_pkg::MEM_CG;
        load = 1'b1;
      end else if (wbyte[7:4] == 4'h4 && tbl1) begin
        next_ac = {3'h0, wbyte[3:0]};
        next_sel = cli_pkg::MEM_ICON;
        load = 1'b1;
      end else if (wbyte[7:1] == 7'h01 || wbyte == `CLI_OP_CLEAR) begin
        next_ac = 7'h00;
        next_sel = cli_pkg::MEM_DD;
      end else if (wbyte[7:4] == 4'h1 && !wbyte[3] && tbl0) begin
        next_ac = step_ac(address_counter, wbyte[2], mem_sel,
                          cfg.two_line, three);
      end
    end else if (dat_wr || dat_rd) begin
      next_ac = step_ac(address_counter, cfg.inc, mem_sel,
                        cfg.two_line, three);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_counter <= 7'h00;
      mem_sel <= cli_pkg::MEM_DD;
    end else begin
      address_counter <= next_ac;
      mem_sel <= next_sel;
    end
  end

  // The read latch is refilled after a load or a read, so a read that
  // follows a plain write returns the value fetched earlier.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_latch <= 8'h00;
    end else if (load || dat_rd) begin
      rd_latch <= mem_rd(next_sel, next_ac);
    end
  end

  // ************************************************************
  // Memories and clear sweep
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pend <= 1'b1;
      clr_busy <= 1'b0;
      clr_addr <= 7'h00;
    end else begin
      init_pend <= 1'b0;
      if (init_go || (ins_go && wbyte == `CLI_OP_CLEAR)) begin
        clr_busy <= 1'b1;
        clr_addr <= 7'h00;
      end else if (clr_busy) begin
        clr_addr <= clr_addr + 7'h01;
        if (clr_addr == `CLI_CLR_LAST) clr_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (clr_busy) begin
      dd_mem[clr_addr] <= `CLI_SPACE;
    end else if (dat_wr) begin
      unique case (mem_sel)
        cli_pkg::MEM_DD: dd_mem[address_counter] <= wbyte;
        cli_pkg::MEM_CG: cg_mem[address_counter[5:0]] <= wbyte;
        cli_pkg::MEM_ICON: icon_mem[address_counter[3:0]] <= wbyte;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Busy timing
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_flag <= 1'b1;
      cnt <= POR_LOAD;
    end else if (init_go) begin
      busy_flag <= 1'b1;
      cnt <= POR_LOAD;
    end else if (ins_go || dat_wr || dat_rd) begin
      busy_flag <= 1'b1;
      cnt <= EXEC_LOAD;
    end else if (busy_flag) begin
      if (cnt != '0) cnt <= cnt - CW'(1);
      else if (!clr_busy) busy_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Settings
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= cli_pkg::cli_cfg_t'(`CLI_CFG_RST);
    end else if (init_go) begin
      cfg <= cli_pkg::cli_cfg_t'(`CLI_CFG_RST);
      cfg.three_line_fix_bit <= three_line_strap;
    end else if (ins_go) begin
      if (wbyte[7:5] == 3'b001) begin
        cfg.bus_width_bit <= wbyte[4];
        cfg.two_line <= wbyte[3];
        cfg.double_height_bit <= wbyte[2];
        cfg.table_select <= wbyte[1:0];
      end else if (wbyte[7:3] == 5'b00001) begin
        {cfg.disp_on, cfg.cursor_on, cfg.blink_on} <= wbyte[2:0];
      end else if (wbyte[7:2] == 6'b000001) begin
        {cfg.inc, cfg.shift} <= wbyte[1:0];
      end else if (wbyte == `CLI_OP_CLEAR) begin
        cfg.inc <= 1'b1;
      end else if (tbl1 && wbyte[7:4] == 4'h1 && wbyte[2:1] == 2'b10) begin
        if (!straps_high) cfg.bias_select <= wbyte[3];
        cfg.three_line_fix_bit <= wbyte[0];
      end else if (tbl1 && wbyte[7:4] == 4'h5) begin
        cfg.icon_on <= wbyte[3];
        if (straps_low) begin
          cfg.boost_on <= wbyte[2];
          cfg.contrast_field[5:4] <= wbyte[1:0];
        end
      end else if (tbl1 && wbyte[7:4] == 4'h6 && straps_low) begin
        cfg.follow_on <= wbyte[3];
        cfg.gain_ratio_field <= wbyte[2:0];
      end else if (tbl1 && wbyte[7:4] == 4'h7 && straps_low) begin
        cfg.contrast_field[3:0] <= wbyte[3:0];
      end else if (tbl2 && wbyte[7:4] == 4'h1) begin
        cfg.double_height_position <= wbyte[3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_top <= 1'b0;
      double_bottom <= 1'b0;
    end else begin
      double_top <= three & cfg.double_height_bit &
                    cfg.double_height_position;
      double_bottom <= three & cfg.double_height_bit &
                       ~cfg.double_height_position;
    end
  end

  // ************************************************************
  // Nibble pairing and APB answer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nib_phase <= 1'b0;
      nib_hold <= 4'h0;
    end else if (init_go || bus8) begin
      nib_phase <= 1'b0;
    end else if (wr_any || rd_any) begin
      nib_phase <= ~nib_phase;
      if (wr_any && !nib_phase) nib_hold <= pwdata[7:4];
    end
  end

  always_comb begin
    rbyte = hit_ins ? {busy_flag, address_counter} : rd_latch;
    rd_word = 32'h0000_0000;
    if (pwrite) rd_word = 32'h0000_0000;
    else if (hit_set) rd_word = 32'(cfg);
    else if (bus8) rd_word[7:0] = rbyte;
    else rd_word[7:4] = nib_phase ? rbyte[3:0] : rbyte[7:4];
  end

  // One wait state: the answer is formed in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      if (acc) begin
        pslverr <= ~(hit_ins | hit_dat | hit_set);
        prdata <= (hit_ins | hit_dat | hit_set) ? rd_word : 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence dd_load_s;
    ins_go && wbyte[7] && !init_go;
  endsequence

  dd_load_a: assert property (dd_load_s |=>
    address_counter == $past(wbyte[6:0]) && mem_sel == cli_pkg::MEM_DD)
    else $error("display address load wrong");
  cg_load_a: assert property (
    ins_go && !init_go && wbyte[7:6] == 2'b01 && tbl0 |=>
    address_counter == {1'b0, $past(wbyte[5:0])} &&
    mem_sel == cli_pkg::MEM_CG) else $error("glyph address load wrong");
  icon_load_a: assert property (
    ins_go && !init_go && wbyte[7:4] == 4'h4 && tbl1 |=>
    address_counter == {3'h0, $past(wbyte[3:0])} &&
    mem_sel == cli_pkg::MEM_ICON) else $error("icon address load wrong");
  one_wrap_a: assert property (
    dat_wr && !init_go && mem_sel == cli_pkg::MEM_DD && cfg.inc &&
    !cfg.two_line && address_counter == 7'h4f |=> address_counter == 7'h00)
    else $error("one line wrap wrong");
  two_wrap_a: assert property (
    dat_wr && !init_go && mem_sel == cli_pkg::MEM_DD && cfg.inc &&
    cfg.two_line && !three_line_strap && address_counter == 7'h27 |=>
    address_counter == 7'h40) else $error("two line wrap wrong");
  three_wrap_a: assert property (
    dat_wr && !init_go && mem_sel == cli_pkg::MEM_DD && cfg.inc &&
    three && address_counter == 7'h2f |=> address_counter == 7'h00)
    else $error("three line wrap wrong");
  busy_read_a: assert property (
    acc && hit_ins && !pwrite && bus8 |=>
    pready && prdata[7:0] == {$past(busy_flag), $past(address_counter)})
    else $error("busy readback wrong");
  busy_hold_a: assert property (
    ins_go |=> busy_flag [*8]) else $error("busy too short");
  contrast_lock_a: assert property (
    !straps_low |=> $stable(cfg.contrast_field) || $past(init_go))
    else $error("contrast changed with straps set");
  bias_lock_a: assert property (
    straps_high && !init_go |=> $stable(cfg.bias_select))
    else $error("bias changed with external bias");
  step_dir_a: assert property (
    dat_rd && !init_go && mem_sel == cli_pkg::MEM_CG && !cfg.inc |=>
    address_counter[5:0] == $past(address_counter[5:0]) - 6'h01)
    else $error("glyph counter step wrong");
endmodule
`default_nettype wire

// [src/cli_defs.svh]
// Offsets, field codes, reset values and timing counts of the LCD core.
//
// Contract
// - Instruction 01aaaaaa in table 0 loads six bits and targets glyph RAM.
// - Instruction 1aaaaaaa loads seven bits and targets display data RAM.
// - One-line mode: display addresses 00H to 4FH form one line.
// - Two-line mode: line one 00H-27H, line two 40H-67H.
// - Three-line mode: lines at 00H-0FH, 10H-1FH and 20H-2FH.
// - Instruction read returns busy on bit 7 and the counter below.
// - Every data write or read steps the counter by one per direction.
// - Data accesses go to the memory chosen by the last address load; clear and return home select display data RAM.
// - First data read without an address load returns stale data.
// - Bias instruction picks quarter or fifth bias; bias bit ignored if straps 11, fix bit still stored.
// - Table 1 opcode 0100 loads a four-bit icon address.
// - Opcode 0101 stores icon enable, booster enable, top contrast bits.
// - Booster, follower, ratio and contrast change only with straps 00.
// - Opcode 0110 stores follower enable and three-bit gain ratio.
// - Opcode 0111 stores the low four contrast bits.
// - Busy stays high about 40 ms after power-on during initialisation.
// - Reset clears display, 8-bit, one line, table 0, display off.
// - Reset also loads icon/bias/power defaults, contrast 20H, ratio 2.
// - The external reset pin performs the same initialisation.
// - In 4-bit mode each byte is two transfers, high nibble first.
// - In 4-bit mode busy and counter read back as two nibbles.
// - Three-line double height: position selects rows 1-16 or 9-24.
// - Table select: 00 normal, 01 table one, 10 table two, 11 reserved.
`ifndef CLI_DEFS_SVH
`define CLI_DEFS_SVH

`define CLI_OFS_INSTR 8'h00
`define CLI_OFS_DATA 8'h04
`define CLI_OFS_SET 8'h08

`define CLI_CLK_NS 25
`define CLI_EXEC_NS 26300
`define CLI_EXEC_CYC ((`CLI_EXEC_NS + `CLI_CLK_NS - 1) / `CLI_CLK_NS)
`define CLI_POR_MS 40
`define CLI_POR_CYC (`CLI_POR_MS * 1000000 / `CLI_CLK_NS)

`define CLI_CFG_RST 25'h1010140
`define CLI_SPACE 8'h20
`define CLI_OP_CLEAR 8'h01

`define CLI_ONE_LAST 7'h4f
`define CLI_TWO_L1_LAST 7'h27
`define CLI_TWO_L2_FIRST 7'h40
`define CLI_TWO_L2_LAST 7'h67
`define CLI_THREE_LAST 7'h2f
`define CLI_CLR_LAST 7'h7f

`endif

// [src/cli_pkg.sv]
// Types shared by the LCD instruction core.
`default_nettype none
package cli_pkg;
  typedef enum logic [1:0] {MEM_DD, MEM_CG, MEM_ICON} cli_mem_t;
  typedef struct packed {
    logic bus_width_bit;
    logic two_line;
    logic double_height_bit;
    logic [1:0] table_select;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic inc;
    logic shift;
    logic bias_select;
    logic three_line_fix_bit;
    logic icon_on;
    logic boost_on;
    logic follow_on;
    logic [2:0] gain_ratio_field;
    logic [5:0] contrast_field;
    logic double_height_position;
  } cli_cfg_t;
endpackage
`default_nettype wire
